// File: rtl/pulse_timer_conflict.sv
// Pulse timer with one-shot down counter, two up counters, capture and bus slave.
//
// Added by the designer: the address map and the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Write to pulse counter beats a coincident decrement; counting resumes from new value.
// - Write at zero with count clock stores value, detects underflow, halts, sets flag.
// - Write one cycle before the underflowing count clock prevents the underflow.
// - Write beats compare B clear; pulse still goes off, counter halts holding written value.
// - Write one cycle before compare B: compare B clears the counter next cycle.
// - Software zero-write clear of underflow flag beats a coincident set.
// - DMA acknowledge clear of underflow flag beats a coincident set.
// - Start trigger with counter at zero never begins the one-shot pulse.
// - Simultaneous start and stop clear counter to zero, no pulse begins.
// - Stop after start before first count clock clears to zero, no pulse.
// - Start trigger coinciding with underflow keeps counter halted at zero.
// - Underflow coinciding with start while decrementing turns pulse output off.
// - Compare A while halted at zero leaves the pulse output negated.
// - Start-with-underflow case sets underflow flag at trigger detection.
// - Up counter write beats the neighbouring clear request.
// - Overflow with clear request clears counter; flag stays unset with enable one.
// - Capture coinciding with clear takes the pre-clear value of first counter.
// - Capture one cycle after clear takes the post-clear value.
// - Compare match follows equality by one cycle, checked only on count changes.
// - Up counter write beats a coincident increment; counting resumes from new value.
// - Overflow flag clear beats a coincident set.
module pulse_timer_conflict
    import pulse_timer_pkg::*;
(
    input  wire  logic                     clk_sys,
    input  wire  logic                     nrst,
    input  wire  pulse_timer_pkg::avs_req_t   avs_req,
    input  wire  pulse_timer_pkg::timer_evt_t evt,
    output logic                           avs_waitrequest,
    output logic [31:0]                    avs_readdata,
    output logic                           oneshot_pulse_output
);
    import pulse_timer_pkg::*;

    timer_state_t s_q;
    timer_state_t s_d;

    // Merges write data into an old word under the byte enables.
    function automatic logic [31:0] merge_be(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  be);
        logic [31:0] m;
        m = old_w;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                m[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return m;
    endfunction : merge_be

    // Value a counter register takes from a bus write.
    function automatic logic [CNT_W-1:0] cnt_wr(input logic [CNT_W-1:0] old_c,
                                                input logic [31:0]      wd,
                                                input logic [3:0]       be);
        logic [31:0] m;
        m = merge_be({8'h00, old_c}, wd, be);
        return m[CNT_W-1:0];
    endfunction : cnt_wr

    // Next value of an up counter: write, then clear, then increment.
    function automatic logic [CNT_W-1:0] up_next(input logic [CNT_W-1:0] c,
                                                 input logic             wr,
                                                 input logic [CNT_W-1:0] wv,
                                                 input logic             clr,
                                                 input logic             inc);
        logic [CNT_W-1:0] n;
        n = c;
        if (wr) begin
            n = wv;
        end else if (clr) begin
            n = CNT_ZERO;
        end else if (inc) begin
            n = c + CNT_ONE;
        end
        return n;
    endfunction : up_next

    // Bus decode; a write takes effect in the cycle waitrequest is low.
    logic             bus_wr;
    logic             wr_ctrl;
    logic             wr_pcnt;
    logic             wr_stat;
    logic             wr_cnt1;
    logic             wr_cnt2;
    logic [CNT_W-1:0] pcnt_wv;
    logic [CNT_W-1:0] cnt1_wv;
    logic [CNT_W-1:0] cnt2_wv;
    logic             stat_lane;
    assign bus_wr    = avs_req.write & ~s_q.waitreq;
    assign wr_ctrl   = bus_wr & (avs_req.address == OFS_CTRL);
    assign wr_pcnt   = bus_wr & (avs_req.address == OFS_PCNT);
    assign wr_stat   = bus_wr & (avs_req.address == OFS_STAT) & avs_req.byteenable[0];
    assign wr_cnt1   = bus_wr & (avs_req.address == OFS_CNT1);
    assign wr_cnt2   = bus_wr & (avs_req.address == OFS_CNT2);
    assign stat_lane = wr_stat;
    assign pcnt_wv   = cnt_wr(s_q.pulse_down_counter, avs_req.writedata, avs_req.byteenable);
    assign cnt1_wv   = cnt_wr(s_q.first_up_counter, avs_req.writedata, avs_req.byteenable);
    assign cnt2_wv   = cnt_wr(s_q.second_up_counter, avs_req.writedata, avs_req.byteenable);

    // Trigger and event terms of the down counter.
    logic stop_ev;
    logic start_ev;
    logic pcnt_zero;
    logic uf_ev;
    logic start_zero;
    logic uf_set;
    logic uf_clr;
    assign stop_ev    = evt.stop_trig | (s_q.stopb_en & s_q.eq_b);
    assign start_ev   = evt.start_trig | (s_q.starta_en & s_q.eq_a);
    assign pcnt_zero  = (s_q.pulse_down_counter == CNT_ZERO);
    assign uf_ev      = (s_q.run == counting) & evt.down_tick & pcnt_zero & ~stop_ev;
    assign start_zero = start_ev & ~stop_ev & ~uf_ev & (s_q.run == halted) & pcnt_zero;
    assign uf_set     = uf_ev | start_zero;
    assign uf_clr     = (stat_lane & ~avs_req.writedata[STAT_UF]) | evt.dma_transfer_ack;

    // Up counter events.
    logic clr_ext;
    logic inc_up;
    logic ovf1_ev;
    logic ovf2_ev;
    assign clr_ext = evt.clear_req & s_q.external_clear_enable;
    assign inc_up  = evt.up_tick & s_q.up_en;
    assign ovf1_ev = inc_up & (s_q.first_up_counter == CNT_MAX);
    assign ovf2_ev = inc_up & (s_q.second_up_counter == CNT_MAX);

    // Read mux; unmapped offsets read as zero.
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = WORD_ZERO;
        case (avs_req.address)
            OFS_CTRL: begin
                rd_mux[CTRL_UP_EN]     = s_q.up_en;
                rd_mux[CTRL_XCLR_EN]   = s_q.external_clear_enable;
                rd_mux[CTRL_STOPB_EN]  = s_q.stopb_en;
                rd_mux[CTRL_STARTA_EN] = s_q.starta_en;
            end
            OFS_PCNT: rd_mux[CNT_W-1:0] = s_q.pulse_down_counter;
            OFS_STAT: begin
                rd_mux[STAT_UF]    = s_q.uf_flag;
                rd_mux[STAT_OVF1]  = s_q.ovf1_flag;
                rd_mux[STAT_OVF2]  = s_q.ovf2_flag;
                rd_mux[STAT_CMFA]  = s_q.compare_a_flag;
                rd_mux[STAT_CMFB]  = s_q.compare_b_flag;
                rd_mux[STAT_PULSE] = s_q.pulse;
                rd_mux[STAT_RUN]   = (s_q.run == counting);
            end
            OFS_CNT1: rd_mux[CNT_W-1:0] = s_q.first_up_counter;
            OFS_CNT2: rd_mux[CNT_W-1:0] = s_q.second_up_counter;
            OFS_CMPA: rd_mux[CNT_W-1:0] = s_q.compare_a_register;
            OFS_CMPB: rd_mux[CNT_W-1:0] = s_q.compare_b_register;
            OFS_OSBR: rd_mux[CNT_W-1:0] = s_q.offset_base_capture_reg;
            default:  rd_mux = WORD_ZERO;
        endcase
    end

    // Next state of the whole block.
    always_comb begin
        s_d = s_q;

        // Bus handshake: one wait cycle, then the request completes.
        if ((avs_req.read | avs_req.write) & s_q.waitreq) begin
            s_d.waitreq = 1'b0;
        end else begin
            s_d.waitreq = 1'b1;
        end
        if (avs_req.read & s_q.waitreq) begin
            s_d.rdata = rd_mux;
        end

        // Plain configuration registers.
        if (wr_ctrl & avs_req.byteenable[0]) begin
            s_d.up_en                 = avs_req.writedata[CTRL_UP_EN];
            s_d.external_clear_enable = avs_req.writedata[CTRL_XCLR_EN];
            s_d.stopb_en              = avs_req.writedata[CTRL_STOPB_EN];
            s_d.starta_en             = avs_req.writedata[CTRL_STARTA_EN];
        end
        if (bus_wr & (avs_req.address == OFS_CMPA)) begin
            s_d.compare_a_register = cnt_wr(s_q.compare_a_register, avs_req.writedata,
                                            avs_req.byteenable);
        end
        if (bus_wr & (avs_req.address == OFS_CMPB)) begin
            s_d.compare_b_register = cnt_wr(s_q.compare_b_register, avs_req.writedata,
                                            avs_req.byteenable);
        end

        // Down counter: stop, underflow, start, decrement; the pulse rises on the first tick.
        if (stop_ev) begin
            s_d.run   = halted;
            s_d.pulse = 1'b0;
            s_d.pulse_down_counter = wr_pcnt ? pcnt_wv : CNT_ZERO;
        end else if (uf_ev) begin
            s_d.run   = halted;
            s_d.pulse = 1'b0;
            s_d.pulse_down_counter = wr_pcnt ? pcnt_wv : CNT_ZERO;
        end else if (start_ev & (s_q.run == halted)) begin
            if (!pcnt_zero) begin
                s_d.run   = counting;
                s_d.pulse = 1'b0;
            end else begin
                s_d.pulse = 1'b0;
            end
            if (wr_pcnt) begin
                s_d.pulse_down_counter = pcnt_wv;
            end
        end else if ((s_q.run == counting) & evt.down_tick) begin
            s_d.pulse = 1'b1;
            s_d.pulse_down_counter = wr_pcnt ? pcnt_wv
                                   : s_q.pulse_down_counter - CNT_ONE;
        end else if (wr_pcnt) begin
            s_d.pulse_down_counter = pcnt_wv;
        end

        // Underflow flag: both clear sources win over the set.
        if (uf_clr) begin
            s_d.uf_flag = 1'b0;
        end else if (uf_set) begin
            s_d.uf_flag = 1'b1;
        end

        // Up counters: write beats clear, clear beats increment.
        s_d.first_up_counter  = up_next(s_q.first_up_counter, wr_cnt1, cnt1_wv,
                                        clr_ext, inc_up);
        s_d.second_up_counter = up_next(s_q.second_up_counter, wr_cnt2, cnt2_wv,
                                        clr_ext, inc_up);

        // Overflow flags: clear wins; a clear request suppresses the set.
        if (stat_lane & ~avs_req.writedata[STAT_OVF1]) begin
            s_d.ovf1_flag = 1'b0;
        end else if (ovf1_ev & ~clr_ext) begin
            s_d.ovf1_flag = 1'b1;
        end
        if (stat_lane & ~avs_req.writedata[STAT_OVF2]) begin
            s_d.ovf2_flag = 1'b0;
        end else if (ovf2_ev & ~clr_ext) begin
            s_d.ovf2_flag = 1'b1;
        end

        // Equality is checked only when the count moves, not on writes.
        s_d.eq_a = ~wr_cnt1 & (clr_ext | inc_up)
                 & (s_d.first_up_counter == s_q.compare_a_register);
        s_d.eq_b = ~wr_cnt2 & (clr_ext | inc_up)
                 & (s_d.second_up_counter == s_q.compare_b_register);

        // Compare flags: a match one cycle after equality, set beats clear.
        if (s_q.eq_a) begin
            s_d.compare_a_flag = 1'b1;
        end else if (stat_lane & ~avs_req.writedata[STAT_CMFA]) begin
            s_d.compare_a_flag = 1'b0;
        end
        if (s_q.eq_b) begin
            s_d.compare_b_flag = 1'b1;
        end else if (stat_lane & ~avs_req.writedata[STAT_CMFB]) begin
            s_d.compare_b_flag = 1'b0;
        end

        // Capture takes the counter as it stands before this edge.
        if (evt.capture_req) begin
            s_d.offset_base_capture_reg = s_q.first_up_counter;
        end
    end

    // State register.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s_q         <= '0;
            s_q.run     <= halted;
            s_q.waitreq <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register.
    assign avs_waitrequest      = s_q.waitreq;
    assign avs_readdata         = s_q.rdata;
    assign oneshot_pulse_output = s_q.pulse;

    // Checks on the conflict behaviour.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    sequence s_start_at_zero;
        start_ev & ~stop_ev & ~uf_ev & (s_q.run == halted) & pcnt_zero;
    endsequence

    sequence s_cnt1_hits_a;
        ~wr_cnt1 & (clr_ext | inc_up) & (s_d.first_up_counter == s_q.compare_a_register);
    endsequence

    property p_wr_beats_dec;
        (s_q.run == counting) & evt.down_tick & ~pcnt_zero & wr_pcnt & ~stop_ev
        |=> (s_q.pulse_down_counter == $past(pcnt_wv)) & (s_q.run == counting);
    endproperty
    a_wr_beats_dec: assert property (p_wr_beats_dec) else $error("write lost to decrement");

    property p_wr_at_uf;
        uf_ev & wr_pcnt & ~uf_clr
        |=> (s_q.run == halted) & s_q.uf_flag & (s_q.pulse_down_counter == $past(pcnt_wv));
    endproperty
    a_wr_at_uf: assert property (p_wr_at_uf) else $error("underflow with write mishandled");

    property p_wr_at_stop;
        stop_ev & wr_pcnt
        |=> ~s_q.pulse & (s_q.run == halted) & (s_q.pulse_down_counter == $past(pcnt_wv));
    endproperty
    a_wr_at_stop: assert property (p_wr_at_stop) else $error("write lost to stop");

    property p_uf_clear_wins;
        uf_set & uf_clr |=> ~s_q.uf_flag;
    endproperty
    a_uf_clear_wins: assert property (p_uf_clear_wins) else $error("underflow set beat clear");

    property p_start_at_zero;
        s_start_at_zero ##0 ~uf_clr |=> ~s_q.pulse & (s_q.run == halted) & s_q.uf_flag;
    endproperty
    a_start_at_zero: assert property (p_start_at_zero) else $error("pulse began at zero");

    property p_start_and_stop;
        start_ev & evt.stop_trig & ~wr_pcnt |=> ~s_q.pulse & (s_q.pulse_down_counter == CNT_ZERO);
    endproperty
    a_start_and_stop: assert property (p_start_and_stop) else $error("start beat stop");

    property p_cnt1_wr_beats_clr;
        wr_cnt1 & clr_ext |=> s_q.first_up_counter == $past(cnt1_wv);
    endproperty
    a_cnt1_wr_beats_clr: assert property (p_cnt1_wr_beats_clr) else $error("clear beat write");

    property p_ovf_clr;
        ovf1_ev & clr_ext & ~wr_cnt1
        |=> (s_q.first_up_counter == CNT_ZERO) & (s_q.ovf1_flag == $past(s_q.ovf1_flag));
    endproperty
    a_ovf_clr: assert property (p_ovf_clr) else $error("overflow set under clear");

    property p_capture_pre;
        evt.capture_req |=> s_q.offset_base_capture_reg == $past(s_q.first_up_counter);
    endproperty
    a_capture_pre: assert property (p_capture_pre) else $error("capture value wrong");

    property p_cmpa_timing;
        s_cnt1_hits_a |-> ##2 s_q.compare_a_flag;
    endproperty
    a_cmpa_timing: assert property (p_cmpa_timing) else $error("compare A flag late");

    property p_pulse_runs;
        s_q.pulse |-> (s_q.run == counting);
    endproperty
    a_pulse_runs: assert property (p_pulse_runs) else $error("pulse high while halted");

    // The pulse may only rise on a count-down clock while counting.
    property p_pulse_tick;
        ~s_q.pulse & ~((s_q.run == counting) & evt.down_tick) |=> ~s_q.pulse;
    endproperty
    a_pulse_tick: assert property (p_pulse_tick)
        else $error("pulse rose before first tick");

    sequence s_wr_then_stop;
        (wr_pcnt & ~stop_ev) ##1 (stop_ev & ~wr_pcnt);
    endsequence

    property p_wr_then_stop;
        s_wr_then_stop |=> s_q.pulse_down_counter == CNT_ZERO;
    endproperty
    a_wr_then_stop: assert property (p_wr_then_stop)
        else $error("compare B clear lost after write");

    property p_start_at_uf;
        uf_ev & start_ev & ~wr_pcnt
        |=> (s_q.run == halted) & ~s_q.pulse & (s_q.pulse_down_counter == CNT_ZERO);
    endproperty
    a_start_at_uf: assert property (p_start_at_uf)
        else $error("start at underflow restarted counter");

    property p_dma_clear_wins;
        uf_set & evt.dma_transfer_ack |=> ~s_q.uf_flag;
    endproperty
    a_dma_clear_wins: assert property (p_dma_clear_wins)
        else $error("dma clear lost to underflow");

endmodule : pulse_timer_conflict

`default_nettype wire

// File: rtl/pulse_timer_pkg.sv
// Package with register map, field layout, state types and bus carriers of the pulse timer.
package pulse_timer_pkg;

    // Counter width and the values that bound it.
    localparam int          CNT_W     = 24;
    localparam logic [23:0] CNT_ZERO  = 24'h00_0000;
    localparam logic [23:0] CNT_MAX   = 24'hFF_FFFF;
    localparam logic [23:0] CNT_ONE   = 24'h00_0001;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // Register byte offsets on the slave port.
    localparam int          ADDR_W    = 8;
    localparam logic [7:0]  OFS_CTRL  = 8'h00;
    localparam logic [7:0]  OFS_PCNT  = 8'h04;
    localparam logic [7:0]  OFS_STAT  = 8'h08;
    localparam logic [7:0]  OFS_CNT1  = 8'h0C;
    localparam logic [7:0]  OFS_CNT2  = 8'h10;
    localparam logic [7:0]  OFS_CMPA  = 8'h14;
    localparam logic [7:0]  OFS_CMPB  = 8'h18;
    localparam logic [7:0]  OFS_OSBR  = 8'h1C;

    // Control register bit positions.
    localparam int CTRL_UP_EN    = 0;
    localparam int CTRL_XCLR_EN  = 1;
    localparam int CTRL_STOPB_EN = 2;
    localparam int CTRL_STARTA_EN = 3;

    // Status register bit positions; flags clear when written with zero.
    localparam int STAT_UF      = 0;
    localparam int STAT_OVF1    = 1;
    localparam int STAT_OVF2    = 2;
    localparam int STAT_CMFA    = 3;
    localparam int STAT_CMFB    = 4;
    localparam int STAT_PULSE   = 5;
    localparam int STAT_RUN     = 6;

    // Down counter run state.
    typedef enum logic {
        halted,
        counting
    } run_t;

    // Avalon-MM request from the master.
    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [31:0]       writedata;
        logic [3:0]        byteenable;
    } avs_req_t;

    // Event strobes from neighbouring logic on the same clock.
    typedef struct packed {
        logic start_trig;
        logic stop_trig;
        logic down_tick;
        logic up_tick;
        logic clear_req;
        logic capture_req;
        logic dma_transfer_ack;
    } timer_evt_t;

    // Complete state of the timer block.
    typedef struct packed {
        run_t             run;
        logic             pulse;
        logic [CNT_W-1:0] pulse_down_counter;
        logic [CNT_W-1:0] first_up_counter;
        logic [CNT_W-1:0] second_up_counter;
        logic [CNT_W-1:0] compare_a_register;
        logic [CNT_W-1:0] compare_b_register;
        logic [CNT_W-1:0] offset_base_capture_reg;
        logic             uf_flag;
        logic             ovf1_flag;
        logic             ovf2_flag;
        logic             compare_a_flag;
        logic             compare_b_flag;
        logic             eq_a;
        logic             eq_b;
        logic             up_en;
        logic             external_clear_enable;
        logic             stopb_en;
        logic             starta_en;
        logic             waitreq;
        logic [31:0]      rdata;
    } timer_state_t;

endpackage : pulse_timer_pkg

// File: testbench/event_source_model.sv
// Model of the neighbouring timer and DMA controller that raise event strobes.
`timescale 1ns/1ns
`default_nettype none
module event_source_model
    import pulse_timer_pkg::*;
(
    input  wire pulse_timer_pkg::timer_evt_t cmd,
    output var  pulse_timer_pkg::timer_evt_t evt
);
    // Strobes pass straight through so each lands on the edge the bench picked.
    assign evt = cmd;
endmodule : event_source_model
`default_nettype wire

// File: testbench/pulse_timer_conflict_logic_test.sv
// Self-checking bench for the pulse timer conflict block.
`timescale 1ns/1ns
`default_nettype none
module pulse_timer_conflict_logic_test;
    import pulse_timer_pkg::*;
    localparam timer_evt_t E_NO = 7'h00;
    localparam timer_evt_t E_ST = 7'h40;
    localparam timer_evt_t E_SP = 7'h20;
    localparam timer_evt_t E_DN = 7'h10;
    localparam timer_evt_t E_UP = 7'h08;
    localparam timer_evt_t E_CL = 7'h04;
    localparam timer_evt_t E_CP = 7'h02;
    logic        clk_sys = 1'b0;
    logic        nrst;
    avs_req_t    req;
    timer_evt_t  ev;
    timer_evt_t  evt;
    logic        avs_waitrequest;
    logic [31:0] avs_readdata;
    logic        oneshot_pulse_output;
    logic [31:0] rq;
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          cycles = 0;

    pulse_timer_conflict u_pulse_timer_conflict (
        .clk_sys              (clk_sys),
        .nrst                 (nrst),
        .avs_req              (req),
        .evt                  (evt),
        .avs_waitrequest      (avs_waitrequest),
        .avs_readdata         (avs_readdata),
        .oneshot_pulse_output (oneshot_pulse_output)
    );
    event_source_model u_event_source_model (
        .cmd (ev),
        .evt (evt)
    );

    // The clock toggles every half period of 2 ns.
    always #2 clk_sys = ~clk_sys;

    // A hung run is cut short and reported as a failure.
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch = n_mismatch + 1;
            final_report();
        end
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    // Compares a seen value with the expected one.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Checks the one-shot output level.
    task automatic pchk(input logic exp);
        chk({31'h000_0000, oneshot_pulse_output}, {31'h000_0000, exp});
    endtask : pchk

    // One bus access; lead 0 puts the event on the completing edge, 1 one edge later,
    // 3 one edge earlier.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input timer_evt_t e, input logic [1:0] lead);
        @(posedge clk_sys);
        req <= '{read: !w, write: w, address: a, writedata: d, byteenable: 4'hF};
        if (lead == 2'h3) ev <= e;
        @(posedge clk_sys);
        ev <= (lead == 2'h0) ? e : E_NO;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
        rq = avs_readdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
        ev <= (lead == 2'h1) ? e : E_NO;
        if (lead == 2'h1) begin
            @(posedge clk_sys);
            ev <= E_NO;
        end
    endtask : bus

    // Plain register write.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, E_NO, 2'h2);
    endtask : wr

    // Register read with comparison.
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000, E_NO, 2'h2);
        chk(rq, exp);
    endtask : rd

    // Two event strobes on consecutive edges.
    task automatic pulse(input timer_evt_t e1, input timer_evt_t e2);
        @(posedge clk_sys);
        ev <= e1;
        @(posedge clk_sys);
        ev <= e2;
        @(posedge clk_sys);
        ev <= E_NO;
    endtask : pulse

    // Loads one, starts and ticks once, leaving the counter running at zero.
    task automatic arm();
        wr(OFS_PCNT, 32'h0000_0001);
        pulse(E_ST, E_NO);
        pulse(E_DN, E_NO);
    endtask : arm

    // Main sequence of scenarios.
    initial begin
        nrst <= 1'b0;
        req <= '0;
        ev <= E_NO;
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        rd(OFS_STAT, 32'h0000_0000);
        rd(OFS_PCNT, 32'h0000_0000);
        rd(8'h20, 32'h0000_0000);
        pchk(1'b0);
        wr(OFS_PCNT, 32'h0000_0002);
        pulse(E_ST, E_NO);
        pchk(1'b0);
        pulse(E_DN, E_DN);
        pchk(1'b1);
        rd(OFS_STAT, 32'h0000_0060);
        pulse(E_DN, E_NO);
        rd(OFS_STAT, 32'h0000_0001);
        pchk(1'b0);
        arm();
        bus(1'b1, OFS_STAT, 32'h0000_0000, E_DN, 2'h0);
        rd(OFS_STAT, 32'h0000_0000);
        pulse(E_ST, E_NO);
        rd(OFS_STAT, 32'h0000_0001);
        pchk(1'b0);
        wr(OFS_STAT, 32'h0000_0000);
        arm();
        pulse(7'h11, E_NO);
        rd(OFS_STAT, 32'h0000_0000);
        arm();
        bus(1'b1, OFS_PCNT, 32'h0000_0009, E_DN, 2'h0);
        rd(OFS_PCNT, 32'h0000_0009);
        rd(OFS_STAT, 32'h0000_0001);
        wr(OFS_STAT, 32'h0000_0000);
        wr(OFS_PCNT, 32'h0000_0003);
        pulse(E_ST, E_NO);
        bus(1'b1, OFS_PCNT, 32'h0000_0007, E_DN, 2'h0);
        rd(OFS_PCNT, 32'h0000_0007);
        pulse(E_DN, E_NO);
        rd(OFS_PCNT, 32'h0000_0006);
        repeat (3) pulse(E_DN, E_DN);
        bus(1'b1, OFS_PCNT, 32'h0000_0004, E_DN, 2'h1);
        rd(OFS_PCNT, 32'h0000_0003);
        rd(OFS_STAT, 32'h0000_0060);
        pulse(E_SP, E_NO);
        wr(OFS_PCNT, 32'h0000_0005);
        pulse(7'h60, E_NO);
        rd(OFS_PCNT, 32'h0000_0000);
        rd(OFS_STAT, 32'h0000_0000);
        wr(OFS_PCNT, 32'h0000_0005);
        pulse(E_ST, E_SP);
        pchk(1'b0);
        rd(OFS_PCNT, 32'h0000_0000);
        pchk(1'b0);
        wr(OFS_CMPA, 32'h0000_1000);
        wr(OFS_CMPB, 32'h0000_1000);
        wr(OFS_CTRL, 32'h0000_0003);
        bus(1'b1, OFS_CNT1, 32'h0000_0010, 7'h0C, 2'h0);
        rd(OFS_CNT1, 32'h0000_0010);
        pulse(E_UP, E_NO);
        rd(OFS_CNT1, 32'h0000_0011);
        pulse(7'h06, E_NO);
        rd(OFS_OSBR, 32'h0000_0011);
        rd(OFS_CNT1, 32'h0000_0000);
        wr(OFS_CNT1, 32'h0000_0020);
        pulse(E_CL, E_CP);
        rd(OFS_OSBR, 32'h0000_0000);
        wr(OFS_STAT, 32'h0000_0000);
        wr(OFS_CNT2, 32'h00FF_FFFF);
        wr(OFS_CNT1, 32'h00FF_FFFF);
        pulse(7'h0C, E_NO);
        rd(OFS_CNT2, 32'h0000_0000);
        rd(OFS_STAT, 32'h0000_0000);
        wr(OFS_CNT1, 32'h00FF_FFFF);
        bus(1'b1, OFS_STAT, 32'h0000_0000, E_UP, 2'h0);
        rd(OFS_STAT, 32'h0000_0000);
        wr(OFS_CMPA, 32'h0000_0005);
        wr(OFS_CNT1, 32'h0000_0005);
        rd(OFS_STAT, 32'h0000_0000);
        wr(OFS_CNT1, 32'h0000_0004);
        pulse(E_UP, E_NO);
        rd(OFS_STAT, 32'h0000_0008);
        wr(OFS_STAT, 32'h0000_0000);
        wr(OFS_CTRL, 32'h0000_000B);
        rd(OFS_CTRL, 32'h0000_000B);
        wr(OFS_CNT1, 32'h0000_0004);
        pulse(E_UP, E_NO);
        rd(OFS_STAT, 32'h0000_0009);
        pchk(1'b0);
        wr(OFS_STAT, 32'h0000_0000);
        wr(OFS_CTRL, 32'h0000_0007);
        wr(OFS_CMPB, 32'h0000_0003);
        wr(OFS_CNT2, 32'h0000_0002);
        wr(OFS_PCNT, 32'h0000_0005);
        pulse(E_ST, E_DN);
        bus(1'b1, OFS_PCNT, 32'h0000_0009, E_UP, 2'h3);
        rd(OFS_PCNT, 32'h0000_0009);
        rd(OFS_STAT, 32'h0000_0010);
        pchk(1'b0);
        wr(OFS_CNT2, 32'h0000_0002);
        wr(OFS_PCNT, 32'h0000_0005);
        pulse(E_ST, E_DN);
        bus(1'b1, OFS_PCNT, 32'h0000_0008, E_UP, 2'h0);
        rd(OFS_PCNT, 32'h0000_0000);
        wr(OFS_STAT, 32'h0000_0000);
        arm();
        pchk(1'b1);
        pulse(7'h50, E_NO);
        rd(OFS_STAT, 32'h0000_0001);
        rd(OFS_PCNT, 32'h0000_0000);
        pchk(1'b0);
        final_report();
    end
endmodule : pulse_timer_conflict_logic_test
`default_nettype wire
